// >>> device_setup_register.sv
// Device setup register bank with the watchdog rate field of the pin word.
// Assumes a synchronous configuration port: one-cycle write and read strobes with a byte
// offset; the decoded settings feed the rest of the motor driver.

`timescale 1ns/1ps
`default_nettype none

module device_setup_register #(
    parameter int unsigned WD_PERIOD0 = device_setup_pkg::WD_RATE0_CYCLES,
    parameter int unsigned WD_PERIOD1 = device_setup_pkg::WD_RATE1_CYCLES,
    parameter int unsigned WD_PERIOD2 = device_setup_pkg::WD_RATE2_CYCLES,
    parameter int unsigned WD_PERIOD3 = device_setup_pkg::WD_RATE3_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Configuration port
    input wire logic [7:0] cfg_addr_in,
    input wire logic cfg_write_in,
    input wire logic cfg_read_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_rvalid_out,
    // Speed command settings
    output logic [14:0] speed_max_freq_hz_out,
    output logic speed_pulse_band_select_out,
    output logic [16:0] speed_pulse_min_hz_out,
    output logic [16:0] speed_pulse_max_hz_out,
    // Device mode settings
    output logic feature_enable_bit15_out,
    output logic spread_spectrum_enable_out,
    output logic low_power_select_out,
    // Clocking settings
    output logic clock_from_external_out,
    output logic reference_clock_enable_out,
    output logic [2:0] reference_clock_rate_out,
    output logic [10:0] reference_clock_khz_out,
    // Outside watchdog
    output logic [1:0] outside_watchdog_rate_out,
    output logic watchdog_check_out
);

    // Register state.
    logic [31:0] setup_word;
    logic [31:0] next_setup_word;
    logic [31:0] pin_word;
    logic [31:0] next_pin_word;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic rvalid;
    logic next_rvalid;

    // Decoded setting state.
    logic [14:0] max_freq;
    logic [14:0] next_max_freq;
    logic band_sel;
    logic next_band_sel;
    logic [16:0] band_min;
    logic [16:0] next_band_min;
    logic [16:0] band_max;
    logic [16:0] next_band_max;
    logic feature_en;
    logic next_feature_en;
    logic spread_en;
    logic next_spread_en;
    logic low_power;
    logic next_low_power;
    logic clk_ext;
    logic next_clk_ext;
    logic ref_en;
    logic next_ref_en;
    logic [2:0] ref_rate;
    logic [2:0] next_ref_rate;
    logic [10:0] ref_khz;
    logic [10:0] next_ref_khz;
    logic [1:0] wd_rate;
    logic [1:0] next_wd_rate;
    logic wd_check;
    logic next_wd_check;

    watchdog_link_if wd_link ();

    if (WD_PERIOD3 < WD_PERIOD2 || WD_PERIOD2 < WD_PERIOD1 || WD_PERIOD1 < WD_PERIOD0) begin : gen_bad_order
        $error("slower watchdog rates need longer periods");
    end

    // Offset decode, shared by the write and read paths.
    function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
        hits = (addr == offset);
    endfunction : hits

    // Unassigned source codes fall back to the internal oscillator, so a stray write
    // can never leave the logic waiting on a clock that is not there.
    function automatic logic source_is_external(input logic [1:0] code);
        case (code)
            device_setup_pkg::CLK_SRC_EXTERNAL: source_is_external = 1'b1; // [RULE_07]
            device_setup_pkg::CLK_SRC_INTERNAL: source_is_external = 1'b0; // [RULE_07]
            default: source_is_external = 1'b0; // [RULE_11]
        endcase
    endfunction : source_is_external

    // Register writes and reads.
    always_comb begin
        next_setup_word = setup_word;
        next_pin_word = pin_word;
        next_rdata = rdata;
        next_rvalid = 1'b0;
        if (cfg_write_in) begin
            if (hits(cfg_addr_in, device_setup_pkg::SETUP_WORD_OFFSET)) begin
                // Reserved bits other than bit 31 are masked off so they always read zero.
                next_setup_word = cfg_wdata_in & device_setup_pkg::SETUP_WORD_MASK; // [RULE_10]
            end
            if (hits(cfg_addr_in, device_setup_pkg::PIN_WORD_OFFSET)) begin
                next_pin_word = cfg_wdata_in & device_setup_pkg::PIN_WORD_MASK;
            end
        end
        if (cfg_read_in) begin
            next_rvalid = 1'b1;
            if (hits(cfg_addr_in, device_setup_pkg::SETUP_WORD_OFFSET)) begin
                next_rdata = setup_word; // [RULE_10]
            end else if (hits(cfg_addr_in, device_setup_pkg::PIN_WORD_OFFSET)) begin
                next_rdata = pin_word;
            end else begin
                next_rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            setup_word <= device_setup_pkg::SETUP_WORD_RESET; // [RULE_10]
            pin_word <= device_setup_pkg::PIN_WORD_RESET;
            rdata <= 32'h00000000;
            rvalid <= 1'b0;
        end else begin
            setup_word <= next_setup_word;
            pin_word <= next_pin_word;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // Decoded settings, registered so every output leaves from a flip-flop.
    // They follow the stored word one cycle later.
    always_comb begin
        next_max_freq = setup_word[device_setup_pkg::MAX_FREQ_MSB:device_setup_pkg::MAX_FREQ_LSB]; // [RULE_02]
        next_feature_en = setup_word[device_setup_pkg::FEATURE_BIT]; // [RULE_03]
        next_spread_en = ~setup_word[device_setup_pkg::SPREAD_OFF_BIT]; // [RULE_04]
        next_low_power = setup_word[device_setup_pkg::LOW_POWER_BIT]; // [RULE_05]
        next_band_sel = setup_word[device_setup_pkg::PULSE_BAND_BIT]; // [RULE_06]
        if (next_band_sel) begin
            next_band_min = device_setup_pkg::BAND_LOW_MIN_HZ; // [RULE_06]
            next_band_max = device_setup_pkg::BAND_LOW_MAX_HZ; // [RULE_06]
        end else begin
            next_band_min = device_setup_pkg::BAND_HIGH_MIN_HZ; // [RULE_06]
            next_band_max = device_setup_pkg::BAND_HIGH_MAX_HZ; // [RULE_06]
        end
        next_clk_ext = source_is_external(
            setup_word[device_setup_pkg::CLK_SRC_MSB:device_setup_pkg::CLK_SRC_LSB]);
        next_ref_en = setup_word[device_setup_pkg::REF_EN_BIT]; // [RULE_08]
        next_ref_rate = setup_word[device_setup_pkg::REF_RATE_MSB:device_setup_pkg::REF_RATE_LSB];
        next_ref_khz = device_setup_pkg::REF_BASE_KHZ << next_ref_rate; // [RULE_09]
        next_wd_rate = pin_word[device_setup_pkg::WD_RATE_MSB:device_setup_pkg::WD_RATE_LSB];
        next_wd_check = wd_link.tick; // [RULE_01]
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            max_freq <= 15'h0000;
            band_sel <= 1'b0;
            band_min <= device_setup_pkg::BAND_HIGH_MIN_HZ;
            band_max <= device_setup_pkg::BAND_HIGH_MAX_HZ;
            feature_en <= 1'b0;
            spread_en <= 1'b1;
            low_power <= 1'b0;
            clk_ext <= 1'b0;
            ref_en <= 1'b0;
            ref_rate <= 3'h0;
            ref_khz <= device_setup_pkg::REF_BASE_KHZ;
            wd_rate <= 2'h0;
            wd_check <= 1'b0;
        end else begin
            max_freq <= next_max_freq;
            band_sel <= next_band_sel;
            band_min <= next_band_min;
            band_max <= next_band_max;
            feature_en <= next_feature_en;
            spread_en <= next_spread_en;
            low_power <= next_low_power;
            clk_ext <= next_clk_ext;
            ref_en <= next_ref_en;
            ref_rate <= next_ref_rate;
            ref_khz <= next_ref_khz;
            wd_rate <= next_wd_rate;
            wd_check <= next_wd_check;
        end
    end

    // The timer reads the stored field directly so a rate change restarts it at once.
    assign wd_link.rate = pin_word[device_setup_pkg::WD_RATE_MSB:device_setup_pkg::WD_RATE_LSB];

    watchdog_check_timer #(
        .COUNT_WIDTH(device_setup_pkg::WD_COUNT_WIDTH),
        .PERIOD0(WD_PERIOD0),
        .PERIOD1(WD_PERIOD1),
        .PERIOD2(WD_PERIOD2),
        .PERIOD3(WD_PERIOD3)
    ) check_timer (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .link(wd_link.timer)
    );

    assign cfg_rdata_out = rdata;
    assign cfg_rvalid_out = rvalid;
    assign speed_max_freq_hz_out = max_freq;
    assign speed_pulse_band_select_out = band_sel;
    assign speed_pulse_min_hz_out = band_min;
    assign speed_pulse_max_hz_out = band_max;
    assign feature_enable_bit15_out = feature_en;
    assign spread_spectrum_enable_out = spread_en;
    assign low_power_select_out = low_power;
    assign clock_from_external_out = clk_ext;
    assign reference_clock_enable_out = ref_en;
    assign reference_clock_rate_out = ref_rate;
    assign reference_clock_khz_out = ref_khz;
    assign outside_watchdog_rate_out = wd_rate;
    assign watchdog_check_out = wd_check;

endmodule : device_setup_register

`default_nettype wire

// >>> device_setup_pkg.sv
// Constants shared by the device setup register bank and its watchdog check timer.
// Assumes a single 10 MHz clock and a configuration port with byte offsets.
//
// Operation
// RULE_01 - Watchdog bits 14-13 pick the check rate: 10, 5, 2 or 1 Hz.
// RULE_02 - Bits 30-16 hold the frequency-speed maximum in Hz, meaning full speed.
// RULE_03 - Bit 15 set enables the test feature; clear keeps it disabled.
// RULE_04 - Bit 14 clear enables spread spectrum; set turns it off.
// RULE_05 - Bit 11 picks low-power mode: clear is standby, set is sleep.
// RULE_06 - Bit 10 clear accepts 325 Hz to 95 kHz PWM; set accepts 10-325 Hz.
// RULE_07 - Source bits 9-8: code 0 internal oscillator, code 3 external clock.
// RULE_08 - Bit 6 set enables the external reference clock; clear disables it.
// RULE_09 - Bits 5-3 give reference clock rate, 8 kHz doubling up to 1024 kHz.
// RULE_10 - Setup word sits at offset a8, 32 bits, resets to zero, reserved zero; the code keeps unused bit 31 writable.
// RULE_11 - Unassigned source codes 1 and 2 fall back to the internal oscillator.

`default_nettype none

package device_setup_pkg;

    // Clock rate.
    localparam int unsigned CLOCK_HZ = 10_000_000;

    // Register offsets on the configuration port.
    localparam logic [7:0] SETUP_WORD_OFFSET = 8'ha8;
    localparam logic [7:0] PIN_WORD_OFFSET = 8'ha6;

    // Reset values and writable masks.
    localparam logic [31:0] SETUP_WORD_RESET = 32'h00000000;
    localparam logic [31:0] PIN_WORD_RESET = 32'h00000000;
    localparam logic [31:0] SETUP_WORD_MASK = 32'hffffcf78;
    localparam logic [31:0] PIN_WORD_MASK = 32'h00006000;

    // Field positions of the setup word.
    localparam int unsigned MAX_FREQ_LSB = 16;
    localparam int unsigned MAX_FREQ_MSB = 30;
    localparam int unsigned FEATURE_BIT = 15;
    localparam int unsigned SPREAD_OFF_BIT = 14;
    localparam int unsigned LOW_POWER_BIT = 11;
    localparam int unsigned PULSE_BAND_BIT = 10;
    localparam int unsigned CLK_SRC_LSB = 8;
    localparam int unsigned CLK_SRC_MSB = 9;
    localparam int unsigned REF_EN_BIT = 6;
    localparam int unsigned REF_RATE_LSB = 3;
    localparam int unsigned REF_RATE_MSB = 5;

    // Field position of the watchdog rate in the pin word.
    localparam int unsigned WD_RATE_LSB = 13;
    localparam int unsigned WD_RATE_MSB = 14;

    // Clock source codes.
    localparam logic [1:0] CLK_SRC_INTERNAL = 2'h0;
    localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h3;

    // Watchdog check rates in Hz and the derived periods in clock cycles.
    localparam int unsigned WD_RATE0_HZ = 10;
    localparam int unsigned WD_RATE1_HZ = 5;
    localparam int unsigned WD_RATE2_HZ = 2;
    localparam int unsigned WD_RATE3_HZ = 1;
    localparam int unsigned WD_RATE0_CYCLES = CLOCK_HZ / WD_RATE0_HZ;
    localparam int unsigned WD_RATE1_CYCLES = CLOCK_HZ / WD_RATE1_HZ;
    localparam int unsigned WD_RATE2_CYCLES = CLOCK_HZ / WD_RATE2_HZ;
    localparam int unsigned WD_RATE3_CYCLES = CLOCK_HZ / WD_RATE3_HZ;
    localparam int unsigned WD_COUNT_WIDTH = 24;

    // PWM speed input bands in Hz.
    localparam logic [16:0] BAND_HIGH_MIN_HZ = 17'h00145;
    localparam logic [16:0] BAND_HIGH_MAX_HZ = 17'h17318;
    localparam logic [16:0] BAND_LOW_MIN_HZ = 17'h0000a;
    localparam logic [16:0] BAND_LOW_MAX_HZ = 17'h00145;

    // Reference clock base rate in kHz; each code step doubles it.
    localparam logic [10:0] REF_BASE_KHZ = 11'h008;

    // Width of the reference rate result in kHz.
    localparam int unsigned REF_KHZ_WIDTH = 11;

endpackage : device_setup_pkg

`default_nettype wire

// >>> watchdog_link_if.sv
// Interface between the setup register bank and the watchdog check timer.
// Assumes both ends share one clock.

`timescale 1ns/1ps
`default_nettype none

interface watchdog_link_if;
    logic [1:0] rate;
    logic tick;

    modport bank (output rate, input tick);
    modport timer (input rate, output tick);
endinterface : watchdog_link_if

`default_nettype wire

// >>> watchdog_check_timer.sv
// Periodic check strobe for the outside watchdog at the selected rate.
// Assumes the rate code comes from a register on the same clock.

`timescale 1ns/1ps
`default_nettype none

module watchdog_check_timer #(
    parameter int unsigned COUNT_WIDTH = device_setup_pkg::WD_COUNT_WIDTH,
    parameter int unsigned PERIOD0 = device_setup_pkg::WD_RATE0_CYCLES,
    parameter int unsigned PERIOD1 = device_setup_pkg::WD_RATE1_CYCLES,
    parameter int unsigned PERIOD2 = device_setup_pkg::WD_RATE2_CYCLES,
    parameter int unsigned PERIOD3 = device_setup_pkg::WD_RATE3_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Link to the register bank
    watchdog_link_if.timer link
);

    logic [COUNT_WIDTH-1:0] count;
    logic [COUNT_WIDTH-1:0] next_count;
    logic [1:0] last_rate;
    logic [1:0] next_last_rate;
    logic tick;
    logic next_tick;
    logic [COUNT_WIDTH-1:0] limit;

    function automatic logic [COUNT_WIDTH-1:0] period_of(input logic [1:0] code);
        case (code)
            2'h0: period_of = COUNT_WIDTH'(PERIOD0);
            2'h1: period_of = COUNT_WIDTH'(PERIOD1);
            2'h2: period_of = COUNT_WIDTH'(PERIOD2);
            default: period_of = COUNT_WIDTH'(PERIOD3);
        endcase
    endfunction : period_of

    if (PERIOD0 < 2 || PERIOD1 < 2 || PERIOD2 < 2 || PERIOD3 < 2) begin : gen_short_period
        $error("watchdog periods must be at least two cycles");
    end
    if (PERIOD0 >= (64'd1 << COUNT_WIDTH) || PERIOD1 >= (64'd1 << COUNT_WIDTH) ||
        PERIOD2 >= (64'd1 << COUNT_WIDTH) || PERIOD3 >= (64'd1 << COUNT_WIDTH)) begin : gen_wide_period
        $error("watchdog period does not fit the counter");
    end

    // A change of rate restarts the period so the first strobe at the new rate is full length.
    always_comb begin
        limit = period_of(link.rate) - COUNT_WIDTH'(1); // [RULE_01]
        next_last_rate = link.rate;
        next_tick = 1'b0;
        if (link.rate != last_rate) begin
            next_count = '0;
        end else if (count >= limit) begin
            next_count = '0;
            next_tick = 1'b1; // [RULE_01]
        end else begin
            next_count = count + COUNT_WIDTH'(1);
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count <= '0;
            last_rate <= 2'h0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            last_rate <= next_last_rate;
            tick <= next_tick;
        end
    end

    assign link.tick = tick;

endmodule : watchdog_check_timer

`default_nettype wire

// >>> device_setup_register_props.sv
// Concurrent checks on the ports of the device setup register bank.
// Assumes one clock; bound into the top module at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module device_setup_register_props #(
    parameter int unsigned WD_PERIOD0 = 20,
    parameter int unsigned WD_PERIOD1 = 40,
    parameter int unsigned WD_PERIOD2 = 100,
    parameter int unsigned WD_PERIOD3 = 200
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Configuration port
    input wire logic [7:0] cfg_addr_in,
    input wire logic cfg_write_in,
    input wire logic cfg_read_in,
    input wire logic [31:0] cfg_wdata_in,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic cfg_rvalid_out,
    // Decoded settings
    input wire logic feature_enable_bit15_out,
    input wire logic spread_spectrum_enable_out,
    input wire logic clock_from_external_out,
    input wire logic [10:0] reference_clock_khz_out,
    input wire logic [1:0] outside_watchdog_rate_out,
    input wire logic watchdog_check_out
);
    logic wr_a8;
    logic [31:0] gap;
    logic [31:0] next_gap;
    logic [31:0] per;
    logic [1:0] chg;
    logic [1:0] next_chg;
    logic [1:0] rate_q;

    assign wr_a8 = cfg_write_in && cfg_addr_in == 8'ha8;

    // A rate change restarts the timer, so the next two pulses are not measured.
    always_comb begin
        next_gap = watchdog_check_out ? 32'h1 : gap + 32'h1;
        next_chg = chg;
        if (rate_q != outside_watchdog_rate_out) begin
            next_chg = 2'h2;
        end else if (watchdog_check_out && chg != 2'h0) begin
            next_chg = chg - 2'h1;
        end
        case (outside_watchdog_rate_out)
            2'h0: per = WD_PERIOD0;
            2'h1: per = WD_PERIOD1;
            2'h2: per = WD_PERIOD2;
            default: per = WD_PERIOD3;
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gap <= 32'h0;
            chg <= 2'h2;
            rate_q <= 2'h0;
        end else begin
            gap <= next_gap;
            chg <= next_chg;
            rate_q <= outside_watchdog_rate_out;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    a_read_answer_timing: assert property (cfg_read_in |=> cfg_rvalid_out)
        else $error("read not answered after one cycle");
    a_no_stray_answer: assert property (!cfg_read_in |=> !cfg_rvalid_out)
        else $error("answer without a read");
    a_unmapped_reads_zero: assert property (cfg_read_in && cfg_addr_in != 8'ha8 &&
        cfg_addr_in != 8'ha6 |=> cfg_rdata_out == 32'h0) else $error("unmapped read not zero");
    a_feature_follows_bit: assert property (wr_a8 |-> ##2
        feature_enable_bit15_out == $past(cfg_wdata_in[15], 2)) else $error("feature bit wrong");
    a_spread_inverted_sense: assert property (wr_a8 |-> ##2
        spread_spectrum_enable_out == !$past(cfg_wdata_in[14], 2)) else $error("spread wrong");
    a_clock_source_decode: assert property (wr_a8 |-> ##2 clock_from_external_out ==
        ($past(cfg_wdata_in[9:8], 2) == 2'h3)) else $error("clock source wrong");
    a_reference_rate_khz: assert property (wr_a8 |-> ##2 reference_clock_khz_out ==
        (11'h008 << $past(cfg_wdata_in[5:3], 2))) else $error("reference rate wrong");
    a_watchdog_rate_field: assert property (cfg_write_in && cfg_addr_in == 8'ha6 |-> ##2
        outside_watchdog_rate_out == $past(cfg_wdata_in[14:13], 2)) else $error("rate wrong");
    // A pulse in the cycle that the rate output moves still belongs to the old period.
    a_watchdog_pulse_spacing: assert property (watchdog_check_out && chg == 2'h0 &&
        rate_q == outside_watchdog_rate_out |-> gap == per)
        else $error("watchdog check spacing wrong");
    a_watchdog_single_pulse: assert property (watchdog_check_out |=> !watchdog_check_out)
        else $error("watchdog check longer than one cycle");

    c_setup_write: cover property (wr_a8);
    c_measured_pulse: cover property (watchdog_check_out && chg == 2'h0);
    c_read_with_write: cover property (cfg_read_in && cfg_write_in);
endmodule : device_setup_register_props

bind device_setup_register device_setup_register_props #(
    .WD_PERIOD0(WD_PERIOD0), .WD_PERIOD1(WD_PERIOD1),
    .WD_PERIOD2(WD_PERIOD2), .WD_PERIOD3(WD_PERIOD3)
) props (.clock_in, .nrst_in, .cfg_addr_in, .cfg_write_in, .cfg_read_in, .cfg_wdata_in,
    .cfg_rdata_out, .cfg_rvalid_out, .feature_enable_bit15_out, .spread_spectrum_enable_out,
    .clock_from_external_out, .reference_clock_khz_out, .outside_watchdog_rate_out,
    .watchdog_check_out);
`default_nettype wire

// >>> device_setup_register_tb.sv
// Self-checking bench for the device setup register bank.
// Drives the ports directly at falling edges; watchdog periods are shortened.
`timescale 1ns/1ps
`default_nettype none
module device_setup_register_tb;
    localparam int unsigned WP [4] = '{20, 40, 100, 200};
    typedef struct packed {
        logic [31:0] w;
        logic [5:0] f;
        logic [10:0] k;
    } row_type;
    // Flags are feature, spread, low power, band, external clock, reference enable.
    localparam row_type ROWS [10] = '{
        '{32'h00000000, 6'h10, 11'h008}, '{32'hffffffff, 6'h2f, 11'h400},
        '{32'h0000b187, 6'h30, 11'h008}, '{32'h00004200, 6'h00, 11'h008},
        '{32'h12340b48, 6'h1b, 11'h010}, '{32'h7fff0410, 6'h14, 11'h020},
        '{32'h00000018, 6'h10, 11'h040}, '{32'h00000020, 6'h10, 11'h080},
        '{32'h00000028, 6'h10, 11'h100}, '{32'h00000030, 6'h10, 11'h200}};
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic rvalid, band, feat, spread, lowp, ext, refen, wd;
    logic [14:0] maxf;
    logic [16:0] minhz, maxhz;
    logic [2:0] rrate;
    logic [10:0] khz;
    logic [1:0] wrate;
    int n_mismatch = 0;
    int n_compared = 0;
    int n;

    always #50 clock_in = ~clock_in;

    device_setup_register #(.WD_PERIOD0(WP[0]), .WD_PERIOD1(WP[1]), .WD_PERIOD2(WP[2]),
        .WD_PERIOD3(WP[3])) uut (.clock_in(clock_in), .nrst_in(nrst_in), .cfg_addr_in(addr),
        .cfg_write_in(wr), .cfg_read_in(rd), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata),
        .cfg_rvalid_out(rvalid), .speed_max_freq_hz_out(maxf), .speed_pulse_band_select_out(band),
        .speed_pulse_min_hz_out(minhz), .speed_pulse_max_hz_out(maxhz),
        .feature_enable_bit15_out(feat), .spread_spectrum_enable_out(spread),
        .low_power_select_out(lowp), .clock_from_external_out(ext),
        .reference_clock_enable_out(refen), .reference_clock_rate_out(rrate),
        .reference_clock_khz_out(khz), .outside_watchdog_rate_out(wrate),
        .watchdog_check_out(wd));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Called at a falling edge; the strobes stay up until idle lowers them.
    task automatic access(input logic [7:0] a, input logic w, input logic r, input logic [31:0] d);
        addr = a;
        wr = w;
        rd = r;
        wdata = d;
        @(negedge clock_in);
    endtask : access

    task automatic idle(input int c);
        wr = 1'b0;
        rd = 1'b0;
        repeat (c) @(negedge clock_in);
    endtask : idle

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        access(a, 1'b0, 1'b1, 32'h0);
        check(rvalid, 32'h1);
        check(rdata, exp);
        idle(1);
    endtask : rd_chk

    task automatic wait_pulse(output int c);
        c = 0;
        do begin
            @(negedge clock_in);
            c++;
        end while (wd !== 1'b1 && c < 1000);
    endtask : wait_pulse

    task automatic finish_test();
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #500000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (10) @(negedge clock_in);
        nrst_in = 1'b1;
        idle(1);
        foreach (ROWS[i]) begin
            access(8'ha8, 1'b1, 1'b0, ROWS[i].w);
            idle(2);
            check({feat, spread, lowp, band, ext, refen}, ROWS[i].f);
            check(khz, ROWS[i].k);
            check(rrate, ROWS[i].w[5:3]);
            check(maxf, ROWS[i].w[30:16]);
            check(minhz, ROWS[i].w[10] ? 17'h0000a : 17'h00145);
            check(maxhz, ROWS[i].w[10] ? 17'h00145 : 17'h17318);
            rd_chk(8'ha8, ROWS[i].w & 32'hffffcf78);
        end
        // A read in the cycle of a write sees the word from before the write.
        access(8'ha8, 1'b1, 1'b1, 32'h00000040);
        check(rdata, 32'h00000030);
        idle(1);
        rd_chk(8'ha8, 32'h00000040);
        nrst_in = 1'b0;
        idle(2);
        check({feat, spread, lowp, band, ext, refen, wd, rvalid}, 8'h40);
        check({1'b0, khz, maxf, wrate, rrate}, {1'b0, 11'h008, 15'h0000, 2'h0, 3'h0});
        check(rdata, 32'h00000000);
        check({15'h0000, minhz}, {15'h0000, 17'h00145});
        check({15'h0000, maxhz}, {15'h0000, 17'h17318});
        nrst_in = 1'b1;
        idle(1);
        access(8'hac, 1'b1, 1'b0, 32'hffffffff);
        idle(2);
        rd_chk(8'ha8, 32'h0);
        rd_chk(8'hac, 32'h0);
        for (int c = 0; c < 4; c++) begin
            access(8'ha6, 1'b1, 1'b0, 32'hffff9fff | 32'(c << 13));
            idle(2);
            check(wrate, c[1:0]);
            rd_chk(8'ha6, 32'(c << 13));
            repeat (3) wait_pulse(n);
            check(n, WP[c]);
        end
        finish_test();
    end
endmodule : device_setup_register_tb
`default_nettype wire
